// file: verilog/opp_optical_pulse.sv
// Optical port conditioning and energy pulse outputs, APB slave.
// Assumes pin inputs synchronous to clock_in and an APB master.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "opp_regs.svh"
module opp_optical_pulse #(
    parameter int SAMPLE_CYCLES = `OPP_SAMPLE_CYCLES, // Sample unit
    parameter int UNIT_CYCLES   = `OPP_UNIT_CYCLES,   // Per interval step
    parameter int CARRIER_DIV   = `OPP_CARRIER_DIV    // Carrier period
) (
    input  wire logic        clock_in,            // System clock
    input  wire logic        rst_n_in,            // Async reset
    input  wire logic        psel_in,             // APB select
    input  wire logic        penable_in,          // APB enable
    input  wire logic        pwrite_in,           // APB write
    input  wire logic [15:0] paddr_in,            // APB byte address
    input  wire logic [31:0] pwdata_in,           // APB write data
    output logic      [31:0] prdata_out,          // APB read data
    output logic             pready_out,          // APB ready
    output logic             pslverr_out,         // APB error
    input  wire logic        uart_txd_in,         // UART transmit line
    output logic             uart_rxd_out,        // UART receive line
    input  wire logic        rx_comparator_in,    // Comparator result
    input  wire logic        optical_receive_pin_in,     // Pin level
    output logic             optical_receive_pin_out,    // Pin drive
    output logic             optical_receive_pin_oe_out, // Pin enable
    input  wire logic        gio1_data_in,        // Line one value
    input  wire logic        gio1_drive_in,       // Line one enable
    output logic             gio1_read_out,       // Line one sensed
    input  wire logic        general_io_line_two_in,     // Line two
    output logic             optical_transmit_pin_out,   // Tx pin
    input  wire logic        real_pulse_req_in,   // Real pulse request
    input  wire logic        react_pulse_req_in,  // Reactive request
    output logic             real_energy_pulse_out,      // Real pulse
    output logic             reactive_energy_pulse_out   // Reactive
);
    opp_pkg::opp_cfg_t cfg_q, cfg_d;
    logic [31:0] prdata_q;
    logic [23:0] tick_cnt_q;
    logic [15:0] car_cnt_q;
    logic        tx_q, rxd_q, real_q, react_q;
    logic        real_act, react_act;

    // Byte address of a register index
    function automatic logic [15:0] addr_of(input logic [15:0] idx);
        addr_of = {idx[13:0], 2'b00};
    endfunction : addr_of

    // Pin level of a pulse, idle high unless inverted
    function automatic logic pulse_lvl(input logic act, input logic inv);
        pulse_lvl = inv ? act : ~act;
    endfunction : pulse_lvl

    // Address decode
    wire sel_pol   = paddr_in == addr_of(`OPP_IDX_POL);
    wire sel_txsel = paddr_in == addr_of(`OPP_IDX_TXSEL);
    wire sel_rxtx  = paddr_in == addr_of(`OPP_IDX_RXTX);
    wire sel_maxw  = paddr_in == addr_of(`OPP_IDX_MAXW);
    wire sel_intv  = paddr_in == addr_of(`OPP_IDX_INTV);
    wire sel_stat  = paddr_in == addr_of(`OPP_IDX_STAT);
    wire mapped    = sel_pol | sel_txsel | sel_rxtx | sel_maxw |
                     sel_intv | sel_stat;
    wire setup     = psel_in & ~penable_in;
    wire wr_en     = psel_in & penable_in & pwrite_in & pready_out;

    // Read words; unused bits read zero
    wire [31:0] rd_pol   = 32'(cfg_q.pulse_polarity_invert) << `OPP_POL_INV_BIT;
    wire [31:0] rd_txsel = (32'(cfg_q.tx_source_select) << `OPP_TXSRC_LSB) |
                           (32'(cfg_q.tx_duty_select) << `OPP_DUTY_LSB);
    wire [31:0] rd_rxtx  = (32'(cfg_q.rx_pin_disable) << `OPP_RXDIS_BIT) |
                           (32'(cfg_q.rx_result_invert) << `OPP_RXINV_BIT) |
                           (32'(cfg_q.tx_modulation_enable) << `OPP_TXMOD_BIT) |
                           (32'(cfg_q.tx_invert) << `OPP_TXINV_BIT);
    wire [31:0] rd_stat  = {28'h0000000, rxd_q, tx_q, react_act, real_act};
    wire [31:0] rd_word  = sel_pol   ? rd_pol :
                           sel_txsel ? rd_txsel :
                           sel_rxtx  ? rd_rxtx :
                           sel_maxw  ? {24'h000000, cfg_q.pulse_width_limit} :
                           sel_intv  ? {24'h000000, cfg_q.pulse_pacing_interval} :
                           sel_stat  ? rd_stat : 32'h00000000;

    // Zero-wait slave; read data is caught in the setup cycle
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in & penable_in & ~mapped;
    assign prdata_out  = prdata_q;

    // Register writes; status is read only
    always_comb begin
        cfg_d = cfg_q;
        if (wr_en && sel_pol)
            cfg_d.pulse_polarity_invert = pwdata_in[`OPP_POL_INV_BIT];
        if (wr_en && sel_txsel) begin
            cfg_d.tx_source_select = opp_pkg::opp_tx_src_t'(pwdata_in[`OPP_TXSRC_LSB +: 2]);
            cfg_d.tx_duty_select   = pwdata_in[`OPP_DUTY_LSB +: 2];
        end
        if (wr_en && sel_rxtx) begin
            cfg_d.rx_pin_disable       = pwdata_in[`OPP_RXDIS_BIT];
            cfg_d.rx_result_invert     = pwdata_in[`OPP_RXINV_BIT];
            cfg_d.tx_modulation_enable = pwdata_in[`OPP_TXMOD_BIT];
            cfg_d.tx_invert            = pwdata_in[`OPP_TXINV_BIT];
        end
        if (wr_en && sel_maxw)
            cfg_d.pulse_width_limit = pwdata_in[7:0];
        if (wr_en && sel_intv)
            cfg_d.pulse_pacing_interval = pwdata_in[7:0];
    end

    // Width time unit: interval steps, or one sample when zero
    wire        paced   = cfg_q.pulse_pacing_interval != 8'h00;
    wire [23:0] period  = paced ?
                          24'(cfg_q.pulse_pacing_interval) * 24'(UNIT_CYCLES) :
                          24'(SAMPLE_CYCLES);
    wire        tick    = tick_cnt_q >= period - 24'h000001;

    // Carrier low for the first part of each period; divider must
    // be a multiple of 16 or the narrow duties round down
    wire [15:0] low_len = 16'(CARRIER_DIV) >> (3'(cfg_q.tx_duty_select) + 3'h1);
    wire        carrier = car_cnt_q >= low_len;
    wire        car_wrap = car_cnt_q >= 16'(CARRIER_DIV) - 16'h0001;

    // Transmit path: select, invert, then modulate zeros only
    wire tx_src = (cfg_q.tx_source_select == opp_pkg::OPP_SRC_UART) ? uart_txd_in :
                  (cfg_q.tx_source_select == opp_pkg::OPP_SRC_GIO2) ?
                  general_io_line_two_in :
                  (cfg_q.tx_source_select == opp_pkg::OPP_SRC_REAL) ?
                  real_q : react_q;
    wire tx_pre = tx_src ^ cfg_q.tx_invert;
    wire tx_d   = (cfg_q.tx_modulation_enable && !tx_pre) ? carrier : tx_pre;

    // Receive path; the invert only reaches the UART side
    wire rxd_d  = cfg_q.rx_pin_disable ? 1'b1 :
                  rx_comparator_in ^ cfg_q.rx_result_invert;
    assign gio1_read_out = cfg_q.rx_pin_disable & optical_receive_pin_in;
    assign optical_receive_pin_out    = gio1_data_in;
    assign optical_receive_pin_oe_out = cfg_q.rx_pin_disable & gio1_drive_in;

    // Pulse channels
    opp_pulse_shaper u_real (
        .clock_in   (clock_in),
        .rst_n_in   (rst_n_in),
        .tick_in    (tick),
        .paced_in   (paced),
        .issue_in   (real_pulse_req_in),
        .width_in   (cfg_q.pulse_width_limit),
        .active_out (real_act)
    );
    opp_pulse_shaper u_react (
        .clock_in   (clock_in),
        .rst_n_in   (rst_n_in),
        .tick_in    (tick),
        .paced_in   (paced),
        .issue_in   (react_pulse_req_in),
        .width_in   (cfg_q.pulse_width_limit),
        .active_out (react_act)
    );

    // Configuration and read capture
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_q    <= '{tx_source_select: opp_pkg::OPP_SRC_UART,
                          pulse_width_limit: `OPP_MAXW_RST,
                          pulse_pacing_interval: `OPP_INTV_RST,
                          default: '0};
            prdata_q <= 32'h00000000;
        end else begin
            cfg_q    <= cfg_d;
            prdata_q <= setup ? rd_word : prdata_q;
        end
    end

    // Timebases
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_cnt_q <= 24'h000000;
            car_cnt_q  <= 16'h0000;
        end else begin
            tick_cnt_q <= tick ? 24'h000000 : tick_cnt_q + 24'h000001;
            car_cnt_q  <= car_wrap ? 16'h0000 : car_cnt_q + 16'h0001;
        end
    end

    // Registered pins; pulses idle high after reset
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_q    <= 1'b1;
            rxd_q   <= 1'b1;
            real_q  <= 1'b1;
            react_q <= 1'b1;
        end else begin
            tx_q    <= tx_d;
            rxd_q   <= rxd_d;
            real_q  <= pulse_lvl(real_act, cfg_q.pulse_polarity_invert);
            react_q <= pulse_lvl(react_act, cfg_q.pulse_polarity_invert);
        end
    end

    assign optical_transmit_pin_out  = tx_q;
    assign uart_rxd_out              = rxd_q;
    assign real_energy_pulse_out     = real_q;
    assign reactive_energy_pulse_out = react_q;

    // Helper: units counted while the real pulse is held
    logic [9:0] real_units_q;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) real_units_q <= 10'h000;
        else real_units_q <= !real_act ? 10'h000 :
                             (tick ? real_units_q + 10'h001 : real_units_q);
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    // Steps of a bypassed request and of a modulated zero
    sequence s_bypass_rise;
        !paced && !real_act && !$past(real_pulse_req_in) && real_pulse_req_in;
    endsequence
    sequence s_zero_mod;
        cfg_q.tx_modulation_enable && !tx_pre;
    endsequence

    AST_DUTY_EDGE: assert property (
        (car_cnt_q == 16'h0000 |-> !carrier) and
        (car_cnt_q == low_len |-> carrier))
        else $error("carrier low share wrong");

    AST_CAR_WRAP: assert property (
        car_wrap |=> car_cnt_q == 16'h0000)
        else $error("carrier period overran");

    AST_RX_COMP: assert property (
        !cfg_q.rx_pin_disable |=> uart_rxd_out ==
        ($past(rx_comparator_in) ^ $past(cfg_q.rx_result_invert)))
        else $error("receive path not from comparator");

    AST_RX_PIN_FREE: assert property (
        !cfg_q.rx_pin_disable |-> !optical_receive_pin_oe_out)
        else $error("receive pin driven while in use");

    AST_RX_DIO: assert property (
        cfg_q.rx_pin_disable |-> gio1_read_out == optical_receive_pin_in
        ##1 uart_rxd_out)
        else $error("pin not handed to line one");

    AST_RX_INV_LOCAL: assert property (
        cfg_q.rx_result_invert && cfg_q.rx_pin_disable
        |-> gio1_read_out == optical_receive_pin_in)
        else $error("invert leaked into line one");

    AST_RX_INV_UART: assert property (
        !cfg_q.rx_pin_disable && cfg_q.rx_result_invert
        |=> uart_rxd_out == !$past(rx_comparator_in))
        else $error("comparator result not inverted");

    AST_TX_SRC: assert property (
        !cfg_q.tx_modulation_enable && !cfg_q.tx_invert &&
        cfg_q.tx_source_select == opp_pkg::OPP_SRC_REAL
        |=> optical_transmit_pin_out == $past(real_energy_pulse_out))
        else $error("transmit source not real pulse");

    AST_TX_UART: assert property (
        !cfg_q.tx_modulation_enable && !cfg_q.tx_invert &&
        cfg_q.tx_source_select == opp_pkg::OPP_SRC_UART
        |=> optical_transmit_pin_out == $past(uart_txd_in))
        else $error("transmit source not uart");

    AST_TX_REACT: assert property (
        !cfg_q.tx_modulation_enable && !cfg_q.tx_invert &&
        cfg_q.tx_source_select == opp_pkg::OPP_SRC_REACT
        |=> optical_transmit_pin_out == $past(reactive_energy_pulse_out))
        else $error("transmit source not reactive pulse");

    AST_TX_INV: assert property (
        !cfg_q.tx_modulation_enable && cfg_q.tx_invert &&
        cfg_q.tx_source_select == opp_pkg::OPP_SRC_GIO2
        |=> optical_transmit_pin_out == !$past(general_io_line_two_in))
        else $error("transmit invert missing");

    AST_TX_MOD: assert property (
        s_zero_mod |=> optical_transmit_pin_out == $past(carrier))
        else $error("zero interval not modulated");

    AST_TX_ONE: assert property (
        cfg_q.tx_modulation_enable && tx_pre |=> optical_transmit_pin_out)
        else $error("one interval was modulated");

    AST_WIDTH_CAP: assert property (
        cfg_q.pulse_width_limit != `OPP_WIDTH_OFF && $stable(cfg_q.pulse_width_limit)
        |-> real_units_q <= {1'b0, cfg_q.pulse_width_limit, 1'b1})
        else $error("pulse exceeded width cap");

    AST_WIDTH_END: assert property (
        real_act && tick && cfg_q.pulse_width_limit != `OPP_WIDTH_OFF &&
        real_units_q == {1'b0, cfg_q.pulse_width_limit, 1'b1} - 10'h001
        |=> !real_act)
        else $error("pulse outlived width cap");

    AST_SAMPLE_UNIT: assert property (
        !paced && $stable(paced) |-> tick_cnt_q < 24'(SAMPLE_CYCLES))
        else $error("sample unit count overrun");

    AST_UNLIMITED: assert property (
        !paced && cfg_q.pulse_width_limit == `OPP_WIDTH_OFF && real_act &&
        real_pulse_req_in |=> real_act)
        else $error("unlimited pulse was cut");

    AST_PACED_ONE: assert property (
        paced && real_act && tick &&
        cfg_q.pulse_width_limit == `OPP_WIDTH_OFF |=> !real_act)
        else $error("paced pulse overran one unit");

    AST_BYPASS: assert property (
        s_bypass_rise |=> real_act ##1 real_energy_pulse_out ==
        $past(cfg_q.pulse_polarity_invert))
        else $error("bypassed pulse not issued at once");

    AST_BYPASS_DROP: assert property (
        !paced && real_act && !real_pulse_req_in |=> !real_act)
        else $error("bypassed pulse outlived request");

    AST_POLARITY: assert property (
        ##1 real_energy_pulse_out ==
        ($past(real_act) ~^ $past(cfg_q.pulse_polarity_invert)))
        else $error("pulse polarity wrong");

    AST_REACT_POL: assert property (
        ##1 reactive_energy_pulse_out ==
        ($past(react_act) ~^ $past(cfg_q.pulse_polarity_invert)))
        else $error("reactive pulse polarity wrong");
endmodule : opp_optical_pulse
`default_nettype wire

// file: verilog/opp_regs.svh
// Register map, field positions, reset values and timing counts
// for the optical port and energy pulse block.
// Assumes a 32-bit APB with one register per aligned word.
`ifndef OPP_REGS_SVH
`define OPP_REGS_SVH

// Register indices; byte address is four times the index
`define OPP_IDX_POL     16'h2004
`define OPP_IDX_TXSEL   16'h2007
`define OPP_IDX_RXTX    16'h2008
`define OPP_IDX_MAXW    16'h2080
`define OPP_IDX_INTV    16'h2081
`define OPP_IDX_STAT    16'h2090

// Field positions
`define OPP_POL_INV_BIT 6
`define OPP_TXSRC_LSB   6
`define OPP_DUTY_LSB    0
`define OPP_RXDIS_BIT   5
`define OPP_RXINV_BIT   4
`define OPP_TXMOD_BIT   1
`define OPP_TXINV_BIT   0

// Reset values and special codes
`define OPP_MAXW_RST    8'hff
`define OPP_INTV_RST    8'h00
`define OPP_WIDTH_OFF   8'hff
`define OPP_PACED_INTV  8'h51

// Timing
`define OPP_CLK_NS      20
`define OPP_SAMPLE_NS   397000
`define OPP_SAMPLE_CYCLES ((`OPP_SAMPLE_NS) / (`OPP_CLK_NS))
`define OPP_UNIT_CYCLES 1
`define OPP_CARRIER_DIV 16

`endif

// file: verilog/opp_pkg.sv
// Types shared by the optical port and energy pulse block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package opp_pkg;

    // Optical transmit pin sources
    typedef enum logic [1:0] {
        OPP_SRC_UART,
        OPP_SRC_GIO2,
        OPP_SRC_REAL,
        OPP_SRC_REACT
    } opp_tx_src_t;

    // Software configuration held by the register file
    typedef struct packed {
        opp_tx_src_t tx_source_select;
        logic [1:0]  tx_duty_select;
        logic        rx_pin_disable;
        logic        rx_result_invert;
        logic        tx_modulation_enable;
        logic        tx_invert;
        logic        pulse_polarity_invert;
        logic [7:0]  pulse_width_limit;
        logic [7:0]  pulse_pacing_interval;
    } opp_cfg_t;

endpackage : opp_pkg
`default_nettype wire

// file: verilog/opp_pulse_shaper.sv
// One energy pulse channel: bypass or paced release and width cap.
// Assumes issue_in is a level from the compute engine, synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "opp_regs.svh"
module opp_pulse_shaper (
    input  wire logic       clock_in,   // System clock
    input  wire logic       rst_n_in,   // Async reset, active low
    input  wire logic       tick_in,    // One pulse per width time unit
    input  wire logic       paced_in,   // Pacing interval nonzero
    input  wire logic       issue_in,   // Pulse request level
    input  wire logic [7:0] width_in,   // Width limit value
    output logic            active_out  // Pulse active, from flop
);
    typedef enum {OPP_IDLE, OPP_BUSY, OPP_SPENT} opp_state_t;
    opp_state_t state_q, state_d;
    logic       issue_q;
    logic [3:0] pend_q, pend_d;
    logic [8:0] wcnt_q, wcnt_d;

    // Cap decode; the all-ones value leaves width unbounded in bypass, one unit when paced
    wire       limit_en  = width_in != `OPP_WIDTH_OFF;
    wire [8:0] limit_val = {width_in, 1'b1};
    wire       rise      = issue_in & ~issue_q;
    wire       busy      = state_q == OPP_BUSY;
    wire       end_now   = busy & tick_in &
                           (limit_en ? (wcnt_q + 9'h001 >= limit_val) : paced_in);
    wire       pend_go   = paced_in & tick_in & ~busy & (pend_q != 4'h0);
    wire       pend_full = pend_q == 4'hf;

    // Queue of paced pulses; a full queue drops the newest request
    assign pend_d = pend_q + ((rise & paced_in & ~pend_full) ? 4'h1 : 4'h0)
                    - (pend_go ? 4'h1 : 4'h0);
    assign wcnt_d = !busy ? 9'h000 : (tick_in ? wcnt_q + 9'h001 : wcnt_q);

    // Channel state
    always_comb begin
        state_d = state_q;
        case (state_q)
            OPP_IDLE: begin
                if (paced_in ? pend_go : issue_in) state_d = OPP_BUSY;
            end
            OPP_BUSY: begin
                if (end_now) state_d = (paced_in || !issue_in) ? OPP_IDLE : OPP_SPENT; // A held bypass request waits in OPP_SPENT until it drops
                else if (!paced_in && !issue_in) state_d = OPP_IDLE;
            end
            OPP_SPENT: begin
                if (paced_in || !issue_in) state_d = OPP_IDLE;
            end
            default: state_d = OPP_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= OPP_IDLE;
            issue_q <= 1'b0;
            pend_q  <= 4'h0;
            wcnt_q  <= 9'h000;
        end else begin
            state_q <= state_d;
            issue_q <= issue_in;
            pend_q  <= pend_d;
            wcnt_q  <= wcnt_d;
        end
    end

    assign active_out = busy;
endmodule : opp_pulse_shaper
`default_nettype wire

// file: sim/opp_partner.sv
// Far side: optical receiver front end and pulse width meter.
// Assumes levels sampled on clock_in; meter watches one pulse pin.
`timescale 1ns/1ps
`default_nettype none
module opp_partner (
    input  wire logic        clock_in,   // System clock
    input  wire logic        rst_n_in,   // Reset, active low
    input  wire logic        light_in,   // Light at the receiver
    input  wire logic        drive_in,   // Device drive on rx pin
    input  wire logic        oe_in,      // Device drives rx pin
    input  wire logic        pulse_in,   // Energy pulse pin
    input  wire logic        act_lvl_in, // Active pulse level
    output logic             comp_out,   // Comparator result
    output logic             wire_out,   // Rx pin wire level
    output logic      [15:0] width_out   // Last active width
);
    logic [15:0] run_q;
    // Device drive wins on the shared pin, else light sets it
    assign comp_out = light_in;
    assign wire_out = oe_in ? drive_in : light_in;
    // Width meter; a pulse still running is not yet reported
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            run_q     <= 16'h0000;
            width_out <= 16'h0000;
        end else if (pulse_in === act_lvl_in) begin
            run_q <= run_q + 16'h0001;
        end else begin
            if (run_q != 16'h0000) width_out <= run_q;
            run_q <= 16'h0000;
        end
    end
endmodule : opp_partner
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the optical port and pulse block.
// Assumes an APB slave with zero wait states and a shortened sample.
`timescale 1ns/1ps
`default_nettype none
`include "opp_regs.svh"
module tb_top;
    logic clock_in, rst_n, psel, penable, pwrite, pready, pslverr, txd, rxd, comp, rpin;
    logic rpin_o, rpin_oe, g1d, g1e, g1r, g2, tx, rreq, qreq, rpls, qpls, light, act, err;
    logic [15:0] paddr, width;
    logic [31:0] pwdata, prdata, rd;
    int bad_count, checked, cyc;
    opp_optical_pulse #(.SAMPLE_CYCLES(40), .UNIT_CYCLES(1), .CARRIER_DIV(16)) dut (
        .clock_in(clock_in), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .uart_txd_in(txd), .uart_rxd_out(rxd),
        .rx_comparator_in(comp), .optical_receive_pin_in(rpin), .optical_receive_pin_out(rpin_o),
        .optical_receive_pin_oe_out(rpin_oe), .gio1_data_in(g1d), .gio1_drive_in(g1e),
        .gio1_read_out(g1r), .general_io_line_two_in(g2), .optical_transmit_pin_out(tx),
        .real_pulse_req_in(rreq), .react_pulse_req_in(qreq), .real_energy_pulse_out(rpls),
        .reactive_energy_pulse_out(qpls));
    opp_partner far (.clock_in(clock_in), .rst_n_in(rst_n), .light_in(light), .drive_in(rpin_o),
        .oe_in(rpin_oe), .pulse_in(rpls), .act_lvl_in(act), .comp_out(comp), .wire_out(rpin),
        .width_out(width));
    // Clock and hang guard; the ceiling is far above the planned run
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("Mismatches %0d of %0d checks", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clock_in);
    endtask : wt
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge clock_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx[13:0], 2'b00};
        pwdata <= wd;
        @(posedge clock_in);
        penable <= 1'b1;
        do begin
            @(posedge clock_in);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rdchk(input logic [15:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    // Reset values, writable bits, unmapped word
    task automatic t_regs();
        logic [15:0] idx [5] = '{`OPP_IDX_POL, `OPP_IDX_TXSEL, `OPP_IDX_RXTX, `OPP_IDX_MAXW, `OPP_IDX_INTV};
        logic [31:0] msk [5] = '{32'h40, 32'hc3, 32'h33, 32'hff, 32'hff};
        for (int i = 0; i < 5; i++) begin
            rdchk(idx[i], (i == 3) ? 32'hff : 32'h0);
            wr(idx[i], 32'hffffffff);
            rdchk(idx[i], msk[i]);
            wr(idx[i], (i == 3) ? 32'hff : 32'h0);
        end
        wr(16'h2000, 32'h1);
        chk(err, 1'b1);
        rdchk(16'h2000, 32'h0);
        wr(`OPP_IDX_STAT, 32'hf);
        rdchk(`OPP_IDX_STAT, 32'h4);
    endtask : t_regs
    // Receive pin routing and comparator inversion
    task automatic t_rx();
        light <= 1'b0;
        wr(`OPP_IDX_RXTX, 32'h0);
        wt(4);
        chk(rxd, 1'b0);
        wr(`OPP_IDX_RXTX, 32'h10);
        wt(4);
        chk(rxd, 1'b1);
        light <= 1'b1;
        wr(`OPP_IDX_RXTX, 32'h30);
        wt(4);
        chk(g1r, 1'b1);
        chk(rxd, 1'b1);
        g1e <= 1'b1;
        wt(3);
        chk(rpin_oe, 1'b1);
        chk(g1r, 1'b0);
        g1d <= 1'b1;
        light <= 1'b0;
        wt(2);
        chk(g1r, 1'b1);
        g1e <= 1'b0;
        g1d <= 1'b0;
        wr(`OPP_IDX_RXTX, 32'h0);
    endtask : t_rx
    // Each source in turn pulls the pin low while the rest idle high
    task automatic t_txsel();
        for (int s = 0; s < 4; s++) begin
            txd <= (s != 0);
            g2 <= (s != 1);
            rreq <= (s == 2);
            qreq <= (s == 3);
            wr(`OPP_IDX_TXSEL, 32'(s) << 6);
            wt(6);
            chk(tx, 1'b0);
            txd <= 1'b1;
            g2 <= 1'b1;
            rreq <= 1'b0;
            qreq <= 1'b0;
            wt(6);
            chk(tx, 1'b1);
        end
        wr(`OPP_IDX_TXSEL, 32'h40);
        wr(`OPP_IDX_RXTX, 32'h1);
        wt(4);
        chk(tx, 1'b0);
        wr(`OPP_IDX_RXTX, 32'h0);
    endtask : t_txsel
    // Low count over two carrier periods for every duty code
    task automatic t_mod();
        int c;
        for (int d = 0; d < 4; d++) begin
            for (int k = 0; k < 3; k++) begin
                txd <= (k != 0);
                wr(`OPP_IDX_TXSEL, 32'(d));
                wr(`OPP_IDX_RXTX, (k == 1) ? 32'h3 : 32'h2);
                wt(4);
                c = 0;
                repeat (32) begin
                    @(posedge clock_in);
                    if (tx === 1'b0) c++;
                end
                chk(32'(c), (k == 2) ? 32'h0 : 32'(2 * (16 >> (d + 1))));
            end
        end
        txd <= 1'b1;
        wr(`OPP_IDX_RXTX, 32'h0);
    endtask : t_mod
    // Bypass pulses: delay, width cap, no cap, polarity
    task automatic t_bypass();
        act <= 1'b0;
        wr(`OPP_IDX_MAXW, 32'h1);
        rreq <= 1'b1;
        wt(3);
        chk(rpls, 1'b0);
        wt(400);
        rreq <= 1'b0;
        wt(4);
        chk(32'(width > 16'd80 && width <= 16'd120), 32'h1);
        act <= 1'b1;
        wr(`OPP_IDX_MAXW, 32'hff);
        wr(`OPP_IDX_POL, 32'h40);
        wt(4);
        chk(qpls, 1'b0);
        rreq <= 1'b1;
        wt(200);
        rreq <= 1'b0;
        wt(4);
        chk(32'(width >= 16'd199 && width <= 16'd201), 32'h1);
        wr(`OPP_IDX_POL, 32'h0);
    endtask : t_bypass
    // Paced pulse through the queue lasts one interval unit
    task automatic t_paced();
        act <= 1'b0;
        wr(`OPP_IDX_INTV, 32'h51);
        rreq <= 1'b1;
        wt(2);
        rreq <= 1'b0;
        wt(300);
        chk(32'(width >= 16'd80 && width <= 16'd82), 32'h1);
        chk(rpls, 1'b1);
    endtask : t_paced
    // Idle inputs at time zero, reset for ten cycles, then scenarios
    initial begin
        {rst_n, psel, penable, pwrite, g1d, g1e, rreq, qreq, light, act} = '0;
        {txd, g2} = 2'b11;
        paddr = 16'h0;
        pwdata = 32'h0;
        wt(10);
        rst_n <= 1'b1;
        t_regs();
        t_rx();
        t_txsel();
        t_mod();
        t_bypass();
        t_paced();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
